// [rtl/ecl_params.svh]
// Constants of the EEPROM channel configuration loader
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH

// EEPROM layout
`define ECL_FLAG_ADDR 16'h0000
`define ECL_FLAG_REPL_BIT 4
`define ECL_FLAG_MAP_BIT 6
`define ECL_FIRST_SLOT 16'h0033
`define ECL_SLOT_HDR 16'h0003
`define ECL_CHAN_LEN 16'h004A
`define ECL_SHARED_LEN 16'h0002
`define ECL_CRC_LEN 16'h0001

// Offsets inside one channel set
`define ECL_OFF_BOOST 7'h00
`define ECL_OFF_CAP1 7'h01
`define ECL_OFF_OVR 7'h02
`define ECL_OFF_MISC 7'h03
`define ECL_OFF_CAP2 7'h04

// Channel register reset values
`define ECL_RST_BOOST 8'h00
`define ECL_RST_CAP1 8'h00
`define ECL_RST_OVR 8'h00
`define ECL_RST_MISC 8'h10
`define ECL_RST_CAP2 8'h0F

// Check value
`define ECL_CRC_POLY 8'h07
`define ECL_CRC_INIT 8'h00

// APB register offsets
`define ECL_REG_CTRL 8'h00
`define ECL_REG_STATUS 8'h04
`define ECL_REG_HDR 8'h08
`define ECL_REG_SHARED 8'h0C
`define ECL_REG_CHAN 8'h10
`define ECL_CHAN_STRIDE 8'h08

// Control fields and header register reset values
`define ECL_CTRL_START 0
`define ECL_CTRL_CRC_EN 1
`define ECL_RST_HDR_START 16'h0033
`define ECL_RST_HDR_CRC 8'h00

`endif

// [rtl/ecl_pkg.sv]
// Types of the EEPROM channel configuration loader
package ecl_pkg;

   typedef struct packed {
      logic [7:0] capSecond;
      logic [7:0] misc;
      logic [7:0] ovr;
      logic [7:0] capFirst;
      logic [7:0] boost;
   } ecl_chan_t;

   typedef struct packed {
      logic dataPathEnable;
      logic mapEnable;
      logic replicate;
      logic crcError;
      logic done;
      logic busy;
   } ecl_status_t;

   typedef enum logic [1:0] {
      ECL_IDLE,
      ECL_FLAGS,
      ECL_SLOT,
      ECL_DONE
   } ecl_state_t;

endpackage : ecl_pkg

// [rtl/ecl_loader.sv]
// EEPROM channel configuration loader with its byte FIFO and APB slave
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "ecl_params.svh"

// ***************************************************
// Byte FIFO
// ***************************************************
module ecl_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr;
   logic [PW-1:0] rdPtr;
   logic [CW-1:0] count;
   logic push;
   logic pop;

   assign inReady = (count != FULL);
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      if (p == PW'(DEPTH - 1)) begin
         return '0;
      end
      return p + 1'b1;
   endfunction : bump

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= bump(wrPtr);
         end
         if (pop) begin
            rdPtr <= bump(rdPtr);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end

endmodule : ecl_fifo

// ***************************************************
// Loader
// ***************************************************
// Notes on behaviour
// - Without headers first slot starts at 0x33
// - Replicate flag: one set for all channels
// - Two shared bytes follow the channel sets
// - Check byte ends slot; headers supply it instead
// - Each channel set is 74 bytes
// - Channel n base is start plus n*74
// - All channel sets share one field layout
// - Offset 0 copied whole into register 0x03
// - Register 0x03 holds four two-bit boost stages
// - Offset 1 bits 7:3 to 0x08 bits 4:0
// - Offset 1 bits 2:0 to 0x09 bits 7:5
// - Offset 3 bits 7:3 to 0x0A bits 4:0
// - Offset 3 bits 2:0 to 0x0B bits 4:2
// - Offset 4 bits 7:6 to 0x0B bits 1:0
// - Data path waits until loading finishes
// - Index above 0: start is 3 plus index times slot length
// - Compare check byte only when checking enabled
module ecl_loader
   import ecl_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int APPLY_DIV = 4,
   parameter int FIFO_DEPTH = 8
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] busAddrIndex,
   output logic eeReadReq,
   output logic [15:0] eeAddr,
   input wire logic eeValid,
   input wire logic [7:0] eeData,
   output ecl_chan_t [CHANNELS-1:0] chanCfg,
   output logic [15:0] sharedCfg,
   output logic loadDone,
   output logic crcError,
   output logic dataPathEnable
);
   localparam int DW = (APPLY_DIV > 1) ? $clog2(APPLY_DIV) : 1;
   localparam logic [2:0] NCH = 3'(CHANNELS);

   ecl_state_t state;
   logic autoStart;
   logic crcEnable;
   logic [15:0] hdrStart;
   logic [7:0] hdrCrc;
   logic replicate;
   logic mapEnable;
   logic [2:0] chanIdx;
   logic [6:0] chanOff;
   logic [1:0] tailCnt;
   logic [7:0] crcAcc;
   logic [15:0] reqLeft;
   logic [DW-1:0] divCnt;
   logic applyTick;
   logic fifoInReady;
   logic fifoOutValid;
   logic [7:0] fifoOutData;
   logic pop;
   logic startLoad;
   logic ctrlStart;
   logic flagPop;
   logic slotPop;
   logic inChan;
   logic lastByte;
   logic replNow;
   logic mapNow;
   logic [15:0] slotLen;
   logic [15:0] slotStart;
   logic [15:0] slotTotal;
   logic [7:0] crcNext;
   logic apbDone;
   logic apbWrite;

   // ***************************************************
   // Field scatter, common to every channel
   // ***************************************************
   function automatic ecl_chan_t apply_byte(input ecl_chan_t c,
      input logic [6:0] off, input logic [7:0] b);
      ecl_chan_t r;
      r = c;
      unique case (off)
         `ECL_OFF_BOOST: r.boost = b;
         `ECL_OFF_CAP1: begin
            r.capFirst[4:0] = b[7:3];
            r.ovr[7:5] = b[2:0];
         end
         `ECL_OFF_OVR: begin
            r.ovr[4:0] = b[7:3];
            r.misc[7:5] = b[2:0];
         end
         `ECL_OFF_MISC: begin
            r.misc[4:0] = b[7:3];
            r.capSecond[4:2] = b[2:0];
         end
         `ECL_OFF_CAP2: r.capSecond[1:0] = b[7:6];
         default: r = c;
      endcase
      return r;
   endfunction : apply_byte

   function automatic logic [7:0] crc_step(input logic [7:0] c,
      input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int k = 0; k < 8; k++) begin
         r = r[7] ? ((r << 1) ^ `ECL_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : crc_step

   // ***************************************************
   // Slot geometry from the flag byte
   // ***************************************************
   assign replNow = fifoOutData[`ECL_FLAG_REPL_BIT];
   assign mapNow = fifoOutData[`ECL_FLAG_MAP_BIT];

   always_comb begin
      slotLen = (replNow ? `ECL_CHAN_LEN
                 : 16'(`ECL_CHAN_LEN * CHANNELS))
                + `ECL_SHARED_LEN + `ECL_CRC_LEN;
      if (mapNow) begin
         slotStart = hdrStart;
         slotTotal = slotLen - `ECL_CRC_LEN;
      end else begin
         if (busAddrIndex == 4'h0) begin
            slotStart = `ECL_FIRST_SLOT;
         end else begin
            slotStart = `ECL_SLOT_HDR
               + 16'(busAddrIndex * slotLen);
         end
         slotTotal = slotLen;
      end
   end

   // ***************************************************
   // Apply-rate divider; a slow apply lets the FIFO fill
   // ***************************************************
   assign applyTick = (divCnt == '0);

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         divCnt <= '0;
      end else if (divCnt == DW'(APPLY_DIV - 1)) begin
         divCnt <= '0;
      end else begin
         divCnt <= divCnt + 1'b1;
      end
   end

   assign pop = fifoOutValid && applyTick
      && (state == ECL_FLAGS || state == ECL_SLOT);
   assign flagPop = pop && (state == ECL_FLAGS);
   assign slotPop = pop && (state == ECL_SLOT);
   assign inChan = chanIdx < (replicate ? 3'h1 : NCH);
   assign lastByte = slotPop && !inChan
      && (tailCnt == (mapEnable ? 2'h1 : 2'h2));
   assign crcNext = crc_step(crcAcc, fifoOutData);
   assign startLoad = (autoStart || ctrlStart)
      && (state == ECL_IDLE || state == ECL_DONE);

   ecl_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rstn(rstn),
      .inValid(eeReadReq && eeValid),
      .inData(eeData),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(fifoOutData),
      .outReady(pop)
   );

   // ***************************************************
   // EEPROM byte requests, one outstanding at a time
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         eeReadReq <= 1'b0;
         eeAddr <= '0;
         reqLeft <= '0;
      end else if (startLoad) begin
         eeReadReq <= 1'b0;
         eeAddr <= `ECL_FLAG_ADDR;
         reqLeft <= 16'h0001;
      end else if (flagPop) begin
         eeAddr <= slotStart;
         reqLeft <= slotTotal;
      end else if (eeReadReq && eeValid) begin
         eeReadReq <= 1'b0;
         eeAddr <= eeAddr + 1'b1;
         reqLeft <= reqLeft - 1'b1;
      end else if (!eeReadReq && reqLeft != '0 && fifoInReady) begin
         // Asking only with room spare keeps the FIFO from overflowing
         eeReadReq <= 1'b1;
      end
   end

   // ***************************************************
   // Sequencer
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state <= ECL_IDLE;
         autoStart <= 1'b1;
         replicate <= 1'b0;
         mapEnable <= 1'b0;
         chanIdx <= '0;
         chanOff <= '0;
         tailCnt <= '0;
      end else begin
         if (startLoad) begin
            autoStart <= 1'b0;
            state <= ECL_FLAGS;
            chanIdx <= '0;
            chanOff <= '0;
            tailCnt <= '0;
         end else if (flagPop) begin
            replicate <= replNow;
            mapEnable <= mapNow;
            state <= ECL_SLOT;
         end else if (slotPop) begin
            if (inChan) begin
               if (chanOff == 7'(`ECL_CHAN_LEN - 1)) begin
                  chanOff <= '0;
                  chanIdx <= chanIdx + 1'b1;
               end else begin
                  chanOff <= chanOff + 1'b1;
               end
            end else begin
               tailCnt <= tailCnt + 1'b1;
            end
            if (lastByte) begin
               state <= ECL_DONE;
            end
         end
      end
   end

   // ***************************************************
   // Check value
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         crcAcc <= `ECL_CRC_INIT;
         crcError <= 1'b0;
      end else if (startLoad) begin
         crcAcc <= `ECL_CRC_INIT;
         crcError <= 1'b0;
      end else if (lastByte) begin
         if (mapEnable) begin
            crcError <= crcEnable && (crcNext != hdrCrc);
         end else begin
            crcError <= crcEnable && (crcAcc != fifoOutData);
         end
      end else if (slotPop) begin
         crcAcc <= crcNext;
      end
   end

   // ***************************************************
   // Completion gates the data path
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         loadDone <= 1'b0;
         dataPathEnable <= 1'b0;
      end else if (startLoad) begin
         loadDone <= 1'b0;
         dataPathEnable <= 1'b0;
      end else if (lastByte) begin
         loadDone <= 1'b1;
         dataPathEnable <= 1'b1;
      end
   end

   // ***************************************************
   // Shared register bytes
   // ***************************************************
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         sharedCfg <= '0;
      end else if (slotPop && !inChan && tailCnt == 2'h0) begin
         sharedCfg[7:0] <= fifoOutData;
      end else if (slotPop && !inChan && tailCnt == 2'h1) begin
         sharedCfg[15:8] <= fifoOutData;
      end
   end

   // ***************************************************
   // Per-channel configuration registers
   // ***************************************************
   generate
      for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
         always_ff @(posedge mclk) begin
            if (!rstn) begin
               chanCfg[i].boost <= `ECL_RST_BOOST;
               chanCfg[i].capFirst <= `ECL_RST_CAP1;
               chanCfg[i].ovr <= `ECL_RST_OVR;
               chanCfg[i].misc <= `ECL_RST_MISC;
               chanCfg[i].capSecond <= `ECL_RST_CAP2;
            end else if (slotPop && inChan
                         && (replicate || chanIdx == 3'(i))) begin
               // Same scatter for every set, replicated or not
               chanCfg[i] <= apply_byte(chanCfg[i], chanOff,
                  fifoOutData);
            end
         end
      end
   endgenerate

   // ***************************************************
   // APB slave, one wait state per transfer
   // ***************************************************
   function automatic logic addr_ok(input logic [7:0] a);
      return (a < (`ECL_REG_CHAN + 8'(CHANNELS) * `ECL_CHAN_STRIDE))
         && (a[1:0] == 2'b00);
   endfunction : addr_ok

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [7:0] rel;
      logic [2:0] ch;
      ecl_status_t st;
      rel = a - `ECL_REG_CHAN;
      ch = rel[5:3];
      st = '{dataPathEnable, mapEnable, replicate, crcError,
             loadDone, state != ECL_IDLE && state != ECL_DONE};
      unique case (a)
         `ECL_REG_CTRL: return {30'h0, crcEnable, 1'b0};
         `ECL_REG_STATUS: return {26'h0, st};
         `ECL_REG_HDR: return {8'h0, hdrCrc, hdrStart};
         `ECL_REG_SHARED: return {16'h0, sharedCfg};
         default: begin
            if (a < `ECL_REG_CHAN || !addr_ok(a)) begin
               return 32'h0;
            end
            if (rel[2]) begin
               return {24'h0, chanCfg[ch].capSecond};
            end
            return {chanCfg[ch].misc, chanCfg[ch].ovr,
                    chanCfg[ch].capFirst, chanCfg[ch].boost};
         end
      endcase
   endfunction : read_word

   assign apbDone = psel && penable && pready;
   assign apbWrite = apbDone && pwrite && !pslverr;
   assign ctrlStart = apbWrite && (paddr == `ECL_REG_CTRL)
      && pwdata[`ECL_CTRL_START];

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            pslverr <= !addr_ok(paddr);
            prdata <= pwrite ? 32'h0 : read_word(paddr);
         end else begin
            pslverr <= 1'b0;
            prdata <= '0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         crcEnable <= 1'b0;
         hdrStart <= `ECL_RST_HDR_START;
         hdrCrc <= `ECL_RST_HDR_CRC;
      end else if (apbWrite && paddr == `ECL_REG_CTRL) begin
         crcEnable <= pwdata[`ECL_CTRL_CRC_EN];
      end else if (apbWrite && paddr == `ECL_REG_HDR) begin
         hdrStart <= pwdata[15:0];
         hdrCrc <= pwdata[23:16];
      end
   end

endmodule : ecl_loader

// [test/ecl_loader_asserts.sv]
// Concurrent checks of the configuration loader seen at its ports
`timescale 1ns/1ps
module ecl_loader_asserts
   import ecl_pkg::*;
#(
   parameter int CHANNELS = 4
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [3:0] busAddrIndex,
   input wire logic eeReadReq,
   input wire logic [15:0] eeAddr,
   input wire logic eeValid,
   input wire logic [7:0] eeData,
   input wire ecl_chan_t [CHANNELS-1:0] chanCfg,
   input wire logic loadDone,
   input wire logic dataPathEnable
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   // ****************************************
   // Slot tracking
   // ****************************************
   logic take, flagTake, repl, mapOn;
   logic [15:0] expStart, startQ, takeCnt, expCnt;
   logic [7:0] cap [5];
   assign take = eeReadReq && eeValid;
   assign flagTake = take && eeAddr == 16'h0000;
   assign expStart = (busAddrIndex == 4'h0) ? 16'h0033 :
      16'(16'h0003 + busAddrIndex * (eeData[4] ? 16'h004D : 16'h012B));
   assign expCnt = (repl ? 16'h004A : 16'h0128) + 16'h0002 +
      (mapOn ? 16'h0000 : 16'h0001);
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         takeCnt <= 16'h0000;
         repl <= 1'b0;
         mapOn <= 1'b0;
         startQ <= 16'h0000;
      end else if (flagTake) begin
         takeCnt <= 16'h0000;
         repl <= eeData[4];
         mapOn <= eeData[6];
         startQ <= expStart;
      end else if (take) begin
         takeCnt <= takeCnt + 16'h0001;
      end
   end
   // Channel 0 head bytes, compared with the registers at the end
   always_ff @(posedge mclk) begin
      if (take && !flagTake && takeCnt < 16'h0005) begin
         cap[takeCnt[2:0]] <= eeData;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   a_req_holds: assert property (eeReadReq && !eeValid |=>
      eeReadReq && $stable(eeAddr)) else $error("request not held");
   a_addr_step: assert property (take && !flagTake |=>
      !eeReadReq && eeAddr == $past(eeAddr) + 16'h0001)
      else $error("slot bytes not consecutive");
   a_slot_start: assert property (flagTake && !eeData[6] |->
      ##[2:24] (eeReadReq && eeAddr == startQ))
      else $error("wrong slot start");
   a_load_len: assert property ($rose(loadDone) |->
      takeCnt == expCnt) else $error("wrong slot length");
   a_boost_copy: assert property ($rose(loadDone) |->
      chanCfg[0].boost == cap[0]) else $error("boost byte wrong");
   a_cap_first: assert property ($rose(loadDone) |->
      chanCfg[0].capFirst[4:0] == cap[1][7:3] &&
      chanCfg[0].ovr[7:5] == cap[1][2:0]) else $error("offset 1 wrong");
   a_misc_bits: assert property ($rose(loadDone) |->
      chanCfg[0].misc[4:0] == cap[3][7:3]) else $error("offset 3 wrong");
   a_cap_split: assert property ($rose(loadDone) |->
      chanCfg[0].capSecond[4:0] == {cap[3][2:0], cap[4][7:6]})
      else $error("split value wrong");
   a_replicate: assert property ($rose(loadDone) && repl |->
      chanCfg[CHANNELS-1] == chanCfg[0]) else $error("not replicated");
   a_path_waits: assert property (dataPathEnable |->
      loadDone && !eeReadReq) else $error("data path too early");
   a_unmapped_keep: assert property (loadDone |->
      chanCfg[0].capFirst[7:5] == 3'h0 && chanCfg[0].capSecond[7:5] == 3'h0)
      else $error("unmapped bits changed");

   c_repl_load: cover property ($rose(loadDone) && repl && !mapOn);
   c_four_load: cover property ($rose(loadDone) && !repl);
   c_map_load: cover property ($rose(loadDone) && mapOn);
endmodule : ecl_loader_asserts

// [test/ecl_eeprom_model.sv]
// Behavioural serial EEPROM answering byte reads of the loader
`timescale 1ns/1ps
module ecl_eeprom_model #(
   parameter int SIZE = 1024
)(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic eeReadReq,
   input wire logic [15:0] eeAddr,
   input wire logic [3:0] latency,
   output logic eeValid,
   output logic [7:0] eeData
);
   // ****************************************
   // Storage and answer
   // ****************************************
   logic [7:0] mem [SIZE];
   logic [3:0] waitCnt;
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         eeValid <= 1'b0;
         eeData <= 8'hA5;
         waitCnt <= 4'h0;
      end else if (!eeValid && eeReadReq && waitCnt == latency) begin
         eeValid <= 1'b1;
         eeData <= mem[eeAddr[9:0]];
         waitCnt <= 4'h0;
      end else begin
         eeValid <= 1'b0;
         // Outside an answer the byte toggles so stale data never matches
         eeData <= ~eeData;
         if (eeReadReq && !eeValid) begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule : ecl_eeprom_model

// [test/testbench.sv]
// Self-checking testbench of the EEPROM channel configuration loader
`timescale 1ns/1ps
module testbench;
   import ecl_pkg::*;
   localparam int CH = 4;
   logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, eeData;
   logic [31:0] pwdata, prdata;
   logic [3:0] busAddrIndex, latency;
   logic eeReadReq, eeValid, loadDone, crcError, dataPathEnable;
   logic [15:0] eeAddr, sharedCfg;
   ecl_chan_t [CH-1:0] chanCfg;
   int failures = 0;
   int testsRun = 0;
   int cycles = 0;

   ecl_loader #(.CHANNELS(CH), .APPLY_DIV(4), .FIFO_DEPTH(8)) ecl_loader_i (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busAddrIndex(busAddrIndex),
      .eeReadReq(eeReadReq), .eeAddr(eeAddr), .eeValid(eeValid),
      .eeData(eeData), .chanCfg(chanCfg), .sharedCfg(sharedCfg),
      .loadDone(loadDone), .crcError(crcError),
      .dataPathEnable(dataPathEnable));
   ecl_eeprom_model ecl_eeprom_model_i (.mclk(mclk), .rstn(rstn),
      .eeReadReq(eeReadReq), .eeAddr(eeAddr), .latency(latency),
      .eeValid(eeValid), .eeData(eeData));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", testsRun, failures);
      if (failures == 0 && testsRun > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         $display("[ERR] %0t run did not finish", $time);
         stop_test();
      end
   end

   task automatic check_eq(input logic [39:0] seen, input logic [39:0] exp);
      testsRun++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check_eq

   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic [7:0] ee(input int a);
      return ecl_eeprom_model_i.mem[a];
   endfunction : ee

   function automatic logic [7:0] slot_crc(input int s, input int n);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < n; i++) begin
         c = c ^ ee(s + i);
         repeat (8) c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
      end
      return c;
   endfunction : slot_crc

   task automatic start_load(input logic crcEn);
      logic [31:0] r;
      logic e;
      apb(1'b1, 8'h00, {30'h0, crcEn, 1'b1}, r, e);
      while (loadDone !== 1'b0) @(posedge mclk);
      while (loadDone !== 1'b1) @(posedge mclk);
   endtask : start_load

   task automatic check_load(input int s, input logic repl, input logic hdr,
      input logic expErr);
      logic [31:0] r;
      logic e;
      logic [7:0] x [5];
      ecl_chan_t got;
      int b;
      for (int c = 0; c < CH; c++) begin
         b = s + (repl ? 0 : c * 74);
         for (int k = 0; k < 5; k++) x[k] = ee(b + k);
         got = chanCfg[c];
         check_eq(40'(got.boost), 40'(x[0]));
         check_eq(40'(got.capFirst), 40'(x[1][7:3]));
         check_eq(40'(got.ovr), 40'({x[1][2:0], x[2][7:3]}));
         check_eq(40'(got.misc), 40'({x[2][2:0], x[3][7:3]}));
         check_eq(40'(got.capSecond), 40'({x[3][2:0], x[4][7:6]}));
      end
      b = s + (repl ? 74 : 296);
      check_eq(40'(sharedCfg), 40'({ee(b + 1), ee(b)}));
      check_eq(40'(crcError), 40'(expErr));
      apb(1'b0, 8'h04, 32'h0, r, e);
      check_eq(40'(r[5:0]), 40'({1'b1, hdr, repl, expErr, 2'h2}));
   endtask : check_load

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      check_eq(40'(dataPathEnable), 40'h0);
      apb(1'b0, 8'h00, 32'h0, r, e);
      check_eq(40'(r), 40'h0);
      apb(1'b0, 8'h08, 32'h0, r, e);
      check_eq(40'({e, r}), 40'h0000000033);
      apb(1'b0, 8'h30, 32'h0, r, e);
      check_eq(40'({e, r}), 40'h0100000000);
      apb(1'b1, 8'h02, 32'hFFFFFFFF, r, e);
      check_eq(40'(e), 40'h1);
   endtask : t_regs

   task automatic t_common();
      while (loadDone !== 1'b1) @(posedge mclk);
      check_load(51, 1'b1, 1'b0, 1'b0);
   endtask : t_common

   task automatic t_four();
      ecl_eeprom_model_i.mem[0] = 8'h00;
      ecl_eeprom_model_i.mem[600] = slot_crc(302, 298);
      busAddrIndex <= 4'h1;
      latency <= 4'h3;
      start_load(1'b1);
      check_load(302, 1'b0, 1'b0, 1'b0);
   endtask : t_four

   task automatic t_crc_bad();
      ecl_eeprom_model_i.mem[600] = ~ee(600);
      latency <= 4'h0;
      start_load(1'b1);
      check_load(302, 1'b0, 1'b0, 1'b1);
   endtask : t_crc_bad

   task automatic t_headers();
      logic [31:0] r;
      logic e;
      ecl_eeprom_model_i.mem[0] = 8'h50;
      apb(1'b1, 8'h08, {8'h00, slot_crc(256, 76), 16'h0100}, r, e);
      apb(1'b0, 8'h08, 32'h0, r, e);
      check_eq(40'(r), 40'({8'h00, slot_crc(256, 76), 16'h0100}));
      start_load(1'b1);
      check_load(256, 1'b1, 1'b1, 1'b0);
   endtask : t_headers

   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      busAddrIndex = 4'h0;
      latency = 4'h0;
      for (int a = 0; a < 1024; a++) begin
         ecl_eeprom_model_i.mem[a] = 8'((a * 29) ^ (a >> 2));
      end
      ecl_eeprom_model_i.mem[0] = 8'h10;
      // Wrong check byte: must be ignored while checking is off
      ecl_eeprom_model_i.mem[127] = ~slot_crc(51, 76);
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      t_regs();
      t_common();
      t_four();
      t_crc_bad();
      t_headers();
      stop_test();
   end
endmodule : testbench

bind ecl_loader ecl_loader_asserts #(.CHANNELS(CHANNELS))
   ecl_loader_asserts_i (
   .mclk(mclk), .rstn(rstn), .busAddrIndex(busAddrIndex),
   .eeReadReq(eeReadReq), .eeAddr(eeAddr), .eeValid(eeValid),
   .eeData(eeData), .chanCfg(chanCfg), .loadDone(loadDone),
   .dataPathEnable(dataPathEnable));
